/* pkg/flpew_pkg.sv */
// flpew_pkg: shared constants and types for the flash page erase/write
// controller. Assumes one 25 MHz system clock and byte-wide SFR access.
`default_nettype none

package flpew_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_WORDS = 64;
  localparam int DATA_W = 16;
  localparam int NUM_WORDS = 4;
  localparam int TMR_W = 17;
  localparam logic [5:0] PAGE_LAST = 6'h3f;

  // ----------------------------------------------------------------
  // register indices on the sfr port
  // ----------------------------------------------------------------
  typedef logic [3:0] flpew_idx_t;
  localparam flpew_idx_t IDX_CTRL0 = 4'h0;
  localparam flpew_idx_t IDX_CTRL2 = 4'h1;
  localparam flpew_idx_t IDX_ADDR_LOW = 4'h2;
  localparam flpew_idx_t IDX_ADDR_HIGH = 4'h3;
  // word n: low byte at base + 2n, high byte one above
  localparam flpew_idx_t IDX_WORD_BASE = 4'h4;

  // ----------------------------------------------------------------
  // field positions and reset value
  // ----------------------------------------------------------------
  localparam int BIT_ENABLED = 7;
  localparam int MODE_LSB = 4;
  localparam int BIT_TRIGGER = 3;
  localparam int BIT_WSTART = 2;
  localparam int BIT_RDEN = 1;
  localparam int BIT_TSEL = 1;
  localparam int BIT_CLEAR = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef logic [2:0] flpew_mode_t;
  localparam flpew_mode_t MODE_WRITE = 3'h0;
  localparam flpew_mode_t MODE_ERASE = 3'h1;
  localparam flpew_mode_t MODE_READ = 3'h3;
  localparam flpew_mode_t MODE_UNLOCK = 3'h6;

  // unlock pattern, words 1..3
  localparam logic [7:0] PAT_W1L = 8'h00;
  localparam logic [7:0] PAT_W2L = 8'h0d;
  localparam logic [7:0] PAT_W3L = 8'hc3;
  localparam logic [7:0] PAT_W1H = 8'h04;
  localparam logic [7:0] PAT_W2H = 8'h09;
  localparam logic [7:0] PAT_W3H = 8'h40;

  // ----------------------------------------------------------------
  // timing, microseconds and cycles
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int ERASE_SEL0_US = 3200;
  localparam int WRITE_SEL0_US = 2200;
  localparam int ERASE_SEL1_US = 3700;
  localparam int WRITE_SEL1_US = 3000;
  localparam int UNLOCK_US = 20;
  localparam int ERASE_SEL0_CYC = ERASE_SEL0_US * CLK_MHZ;
  localparam int WRITE_SEL0_CYC = WRITE_SEL0_US * CLK_MHZ;
  localparam int ERASE_SEL1_CYC = ERASE_SEL1_US * CLK_MHZ;
  localparam int WRITE_SEL1_CYC = WRITE_SEL1_US * CLK_MHZ;
  localparam int UNLOCK_CYC = UNLOCK_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_UNLOCK,
    ST_ERASE,
    ST_WRITE
  } flpew_state_e;

  // command to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic [8:0] page;
    logic [63:0] tag;
    logic word_valid;
    logic [5:0] word_idx;
    logic [15:0] word_data;
  } flpew_flash_s;

endpackage

`default_nettype wire

/* verilog/flpew_timer.sv */
// flpew_timer: loadable down counter with busy level and done pulse.
// Assumes load values of at least one.
`timescale 1ns/10ps
`default_nettype none

module flpew_timer #(
  parameter int W = 17
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic load, // start counting
  input wire logic [W-1:0] load_val, // cycles to run
  output logic busy, // counting
  output logic done // last cycle
);

  logic [W-1:0] cnt;

  assign busy = (cnt != '0);
  assign done = (cnt == W'(1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (busy) begin
      cnt <= cnt - W'(1);
    end
  end

endmodule

`default_nettype wire

/* verilog/flpew_wbuf.sv */
// flpew_wbuf: one-page write buffer with per-word tags and a walking
// clear. Assumes writer and reader on the same clock.
`timescale 1ns/10ps
`default_nettype none

module flpew_wbuf #(
  parameter int WORDS = 64,
  parameter int DW = 16,
  parameter int IW = 6
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic wr_en, // load one word
  input wire logic [IW-1:0] wr_idx, // word index
  input wire logic [DW-1:0] wr_data, // word value
  input wire logic clr_start, // begin clearing
  output logic clr_busy, // clearing
  output logic clr_done, // last clear cycle
  input wire logic [IW-1:0] rd_idx, // read index
  output logic [DW-1:0] rd_data, // read value
  output logic [WORDS-1:0] tag_vec // tagged words
);

  logic [DW-1:0] mem [WORDS];
  logic [IW-1:0] clr_idx;

  assign clr_done = clr_busy && (clr_idx == IW'(WORDS - 1));
  assign rd_data = mem[rd_idx];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_busy <= 1'b0;
      clr_idx <= '0;
    end else if (clr_start) begin
      clr_busy <= 1'b1;
      clr_idx <= '0;
    end else if (clr_busy) begin
      clr_busy <= !clr_done;
      clr_idx <= clr_idx + IW'(1);
    end
  end

  // one entry per cycle; a load to the entry being cleared wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
      tag_vec <= '0;
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        if (clr_busy && clr_idx == IW'(i)) begin
          mem[i] <= '0; // [RQ21]
          tag_vec[i] <= 1'b0;
        end
        if (wr_en && wr_idx == IW'(i)) begin
          mem[i] <= wr_data;
          tag_vec[i] <= 1'b1; // [RQ12]
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/flpew_ctrl.sv */
// flpew_ctrl: flash page erase/write controller, register side facing
// the cpu sfr port, command side facing the flash array.
// Assumes the cpu port runs on ref_clk; the array obeys flash_cmd.
//
// Function
// RQ1: writing 1 starts buffer clear; bit falls to 0 when clearing ends.
// RQ2: address is 15 bits; high register bit 7 reads zero.
// RQ3: low byte write of word 0 stores only that register.
// RQ4: high byte write of word 0 loads both bytes into buffer.
// RQ5: each such buffer load increments the address by one.
// RQ6: three more read/write data words, low and high bytes.
// RQ7: enabled status is set only by a successful unlock.
// RQ8: erase and write start only while enabled status is 1.
// RQ9: software loads page start then dummy high writes to tag words.
// RQ10: each dummy high write advances the address by one.
// RQ11: address stops at in-page index all ones.
// RQ12: erase covers only tagged words.
// RQ13: software blank-checks the page and repeats erase on failure.
// RQ14: on write mismatch software clears the buffer and rewrites.
// RQ15: software clearing the enabled bit disables, no unlock needed.
// RQ16: no flash change until unlock has succeeded.
// RQ17: mode 000 write, 001 erase, 110 unlock, 011 read.
// RQ18: write start stays high for program time chosen by select bit.
// RQ19: unlock needs unlock mode, trigger and pattern before timeout.
// RQ20: timeout clears trigger; wrong pattern leaves locked.
// RQ21: buffer holds 64 words by low address; clear zeroes all.
`timescale 1ns/10ps
`default_nettype none

module flpew_ctrl
  import flpew_pkg::*;
#(
  parameter int ERASE0_CYC = flpew_pkg::ERASE_SEL0_CYC,
  parameter int WRITE0_CYC = flpew_pkg::WRITE_SEL0_CYC,
  parameter int ERASE1_CYC = flpew_pkg::ERASE_SEL1_CYC,
  parameter int WRITE1_CYC = flpew_pkg::WRITE_SEL1_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic sfr_wr, // one-cycle write strobe
  input wire flpew_pkg::flpew_idx_t sfr_addr, // register index
  input wire logic [7:0] sfr_wdata, // write byte
  output logic [7:0] sfr_rdata, // byte at last cycle's index
  output var flpew_pkg::flpew_flash_s flash_cmd // to flash array
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  flpew_state_e state;
  logic enabled, trigger, wstart, rden, tsel, clr_bit, streaming;
  flpew_mode_t mode;
  logic [ADDR_W-1:0] addr;
  logic [7:0] word_lo [NUM_WORDS], word_hi [NUM_WORDS];
  logic [PAGE_W-1:0] stream_idx;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_ctrl0, wr_ctrl2, wr_alow, wr_ahigh;
  logic [NUM_WORDS-1:0] wr_lo, wr_hi;
  flpew_mode_t new_mode;
  logic trig_go, op_mode_ok, go, go_erase, pat_ok;
  logic unl_done, unl_busy, prog_done, prog_busy;
  logic clr_go, clr_busy, clr_done, addr_sat;
  logic [ADDR_W-1:0] next_addr;
  logic [TMR_W-1:0] prog_len;
  logic [DATA_W-1:0] rd_word;
  logic [PAGE_WORDS-1:0] tag_vec;
  logic [7:0] reg_view [16];

  assign wr_ctrl0 = sfr_wr && (sfr_addr == IDX_CTRL0);
  assign wr_ctrl2 = sfr_wr && (sfr_addr == IDX_CTRL2);
  assign wr_alow = sfr_wr && (sfr_addr == IDX_ADDR_LOW);
  assign wr_ahigh = sfr_wr && (sfr_addr == IDX_ADDR_HIGH);
  for (genvar n = 0; n < NUM_WORDS; n++) begin : g_dec
    assign wr_lo[n] = sfr_wr && (sfr_addr == IDX_WORD_BASE + 4'(2 * n));
    assign wr_hi[n] = sfr_wr &&
                      (sfr_addr == IDX_WORD_BASE + 4'(2 * n + 1));
  end
  assign new_mode = sfr_wdata[MODE_LSB +: 3];
  // unlock only from idle, with the unlock code in the same write
  assign trig_go = wr_ctrl0 && sfr_wdata[BIT_TRIGGER] &&
                   (new_mode == MODE_UNLOCK) && (state == ST_IDLE); // [RQ19]
  assign op_mode_ok = (new_mode == MODE_WRITE) ||
                      (new_mode == MODE_ERASE); // [RQ17]
  // locked device, busy clear or running op: the start bit is dropped
  assign go = wr_ctrl0 && sfr_wdata[BIT_WSTART] && enabled &&
              op_mode_ok && (state == ST_IDLE) && !clr_busy; // [RQ8] [RQ16]
  assign go_erase = go && (new_mode == MODE_ERASE);
  assign pat_ok = (word_lo[1] == PAT_W1L) && (word_hi[1] == PAT_W1H) &&
                  (word_lo[2] == PAT_W2L) && (word_hi[2] == PAT_W2H) &&
                  (word_lo[3] == PAT_W3L) &&
                  (word_hi[3] == PAT_W3H); // [RQ19]
  // buffer is emptied by software or after each finished operation
  assign clr_go = (wr_ctrl2 && sfr_wdata[BIT_CLEAR]) || prog_done;
  assign addr_sat = (addr[PAGE_W-1:0] == PAGE_LAST); // [RQ11]
  assign next_addr = addr_sat ? addr : addr + ADDR_W'(1); // [RQ5] [RQ10]
  assign prog_len = go_erase ?
                    (tsel ? TMR_W'(ERASE1_CYC) : TMR_W'(ERASE0_CYC)) :
                    (tsel ? TMR_W'(WRITE1_CYC) : TMR_W'(WRITE0_CYC)); // [RQ18]

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  assign reg_view[IDX_CTRL0] = {enabled, mode, trigger, wstart, rden, 1'b0};
  assign reg_view[IDX_CTRL2] = {6'h00, tsel, clr_bit};
  assign reg_view[IDX_ADDR_LOW] = addr[7:0];
  assign reg_view[IDX_ADDR_HIGH] = {1'b0, addr[14:8]}; // [RQ2]
  for (genvar n = 0; n < NUM_WORDS; n++) begin : g_view
    assign reg_view[IDX_WORD_BASE + 4'(2 * n)] = word_lo[n]; // [RQ6]
    assign reg_view[IDX_WORD_BASE + 4'(2 * n + 1)] = word_hi[n];
  end
  assign reg_view[12] = 8'h00;
  assign reg_view[13] = 8'h00;
  assign reg_view[14] = 8'h00;
  assign reg_view[15] = 8'h00;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  flpew_timer #(
    .W(TMR_W)
  ) u_unlock_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(trig_go),
    .load_val(TMR_W'(UNLOCK_CYC)),
    .busy(unl_busy),
    .done(unl_done)
  );
  flpew_timer #(
    .W(TMR_W)
  ) u_prog_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(go),
    .load_val(prog_len),
    .busy(prog_busy),
    .done(prog_done)
  );
  flpew_wbuf #(
    .WORDS(PAGE_WORDS),
    .DW(DATA_W),
    .IW(PAGE_W)
  ) u_wbuf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_hi[0]), // [RQ3] [RQ4]
    .wr_idx(addr[PAGE_W-1:0]), // [RQ21]
    .wr_data({sfr_wdata, word_lo[0]}), // [RQ4]
    .clr_start(clr_go),
    .clr_busy(clr_busy),
    .clr_done(clr_done),
    .rd_idx(stream_idx),
    .rd_data(rd_word),
    .tag_vec(tag_vec)
  );

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled <= 1'b0;
      mode <= RST_BYTE[2:0];
      trigger <= 1'b0;
      wstart <= 1'b0;
      rden <= 1'b0;
      tsel <= 1'b0;
      clr_bit <= 1'b0;
    end else begin
      // hardware set beats software clear in the same cycle
      if (unl_done && pat_ok) begin
        enabled <= 1'b1; // [RQ7]
      end else if (wr_ctrl0 && !sfr_wdata[BIT_ENABLED]) begin
        enabled <= 1'b0; // [RQ15]
      end
      if (wr_ctrl0) begin
        mode <= new_mode;
        rden <= sfr_wdata[BIT_RDEN];
      end
      trigger <= trig_go || (trigger && !unl_done); // [RQ20]
      wstart <= go || (wstart && !prog_done); // [RQ18]
      if (wr_ctrl2) begin
        tsel <= sfr_wdata[BIT_TSEL];
      end
      clr_bit <= clr_go || (clr_bit && !clr_done); // [RQ1]
    end
  end

  // ----------------------------------------------------------------
  // address and data words
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
    end else if (wr_hi[0]) begin
      addr <= next_addr; // [RQ5] [RQ10] [RQ11]
    end else if (wr_alow) begin
      addr[7:0] <= sfr_wdata;
    end else if (wr_ahigh) begin
      addr[14:8] <= sfr_wdata[6:0]; // [RQ2]
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < NUM_WORDS; n++) begin
        word_lo[n] <= RST_BYTE;
        word_hi[n] <= RST_BYTE;
      end
    end else begin
      for (int n = 0; n < NUM_WORDS; n++) begin
        if (wr_lo[n]) begin
          word_lo[n] <= sfr_wdata; // [RQ3] [RQ6]
        end
        if (wr_hi[n]) begin
          word_hi[n] <= sfr_wdata; // [RQ6]
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_go) begin
            state <= ST_UNLOCK;
          end else if (go) begin
            state <= go_erase ? ST_ERASE : ST_WRITE;
          end
        end
        ST_UNLOCK: begin
          if (unl_done) begin
            state <= ST_IDLE;
          end
        end
        ST_ERASE, ST_WRITE: begin
          if (prog_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // write hands the page to the array once, one word a cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      streaming <= 1'b0;
      stream_idx <= '0;
    end else if (go && !go_erase) begin
      streaming <= 1'b1;
      stream_idx <= '0;
    end else if (streaming) begin
      streaming <= (stream_idx != PAGE_LAST);
      stream_idx <= stream_idx + PAGE_W'(1);
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= RST_BYTE;
      flash_cmd <= '0;
    end else begin
      sfr_rdata <= reg_view[sfr_addr];
      flash_cmd.erase <= (state == ST_ERASE); // [RQ12]
      flash_cmd.write <= (state == ST_WRITE);
      flash_cmd.page <= addr[ADDR_W-1:PAGE_W];
      flash_cmd.tag <= tag_vec; // [RQ12]
      flash_cmd.word_valid <= streaming && tag_vec[stream_idx];
      flash_cmd.word_idx <= stream_idx;
      flash_cmd.word_data <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_op_start;
    go;
  endsequence
  sequence s_op_hold;
    wstart [*8];
  endsequence
  chk_clear_ends: assert property ( // [RQ1]
    $rose(clr_bit) |-> ##[1:70] !clr_bit)
    else $error("buffer clear bit stuck");
  chk_addr_hi_b7: assert property ( // [RQ2]
    $past(sfr_addr) == IDX_ADDR_HIGH |-> !sfr_rdata[7])
    else $error("address high bit 7 not zero");
  chk_low_no_load: assert property ( // [RQ3]
    wr_lo[0] |=> tag_vec == $past(tag_vec) || $past(clr_busy))
    else $error("low byte loaded buffer");
  chk_high_load_incr: assert property ( // [RQ4] [RQ5]
    wr_hi[0] && !addr_sat |=> addr == $past(addr) + ADDR_W'(1) &&
    tag_vec[$past(addr[PAGE_W-1:0])])
    else $error("high byte write did not load and advance");
  chk_page_saturate: assert property ( // [RQ11]
    wr_hi[0] && addr_sat |=> addr == $past(addr))
    else $error("address crossed page boundary");
  chk_word_store: assert property ( // [RQ6]
    wr_lo[2] |=> word_lo[2] == $past(sfr_wdata))
    else $error("data word not stored");
  chk_enable_source: assert property ( // [RQ7]
    $rose(enabled) |-> $past(unl_done) && $past(pat_ok))
    else $error("enabled set without unlock");
  chk_locked_no_op: assert property ( // [RQ8] [RQ16]
    state == ST_IDLE && !enabled |=> state != ST_ERASE && state != ST_WRITE)
    else $error("operation started while locked");
  chk_op_hold: assert property (s_op_start |=> s_op_hold) // [RQ18]
    else $error("write start bit fell early");
  chk_wstart_timer: assert property (wstart == prog_busy) // [RQ18]
    else $error("write start bit and program timer disagree");
  chk_mode_code: assert property ( // [RQ17]
    go |=> (state == ST_ERASE) == (mode == MODE_ERASE))
    else $error("operation started in wrong mode");
  chk_unlock_arm: assert property (trig_go |=> trigger && unl_busy) // [RQ19]
    else $error("unlock did not arm");
  chk_trigger_drop: assert property (unl_done |=> !trigger) // [RQ20]
    else $error("trigger not cleared at timeout");
  chk_disable: assert property ( // [RQ15]
    wr_ctrl0 && !sfr_wdata[BIT_ENABLED] && !unl_done |=> !enabled)
    else $error("enabled bit did not clear");

endmodule

`default_nettype wire

/* sim/flpew_flash_model.sv */
// flpew_flash_model: behavioural flash array behind flash_cmd.
// Assumes commands arrive registered on ref_clk.
`timescale 1ns/10ps
`default_nettype none

module flpew_flash_model (
  input wire logic ref_clk, // system clock
  input wire flpew_pkg::flpew_flash_s flash_cmd // from controller
);
  import flpew_pkg::*;

  logic [15:0] mem [0:32767];
  logic erase_q;

  // cells start all ones so an erase to zero is visible
  initial begin
    erase_q = 1'b0;
    foreach (mem[i]) mem[i] = 16'hffff;
  end

  always @(posedge ref_clk) begin
    erase_q <= flash_cmd.erase;
    if (flash_cmd.erase && !erase_q) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        if (flash_cmd.tag[i]) mem[{flash_cmd.page, i[5:0]}] = 16'h0000;
      end
    end
    if (flash_cmd.write && flash_cmd.word_valid) begin
      mem[{flash_cmd.page, flash_cmd.word_idx}] = flash_cmd.word_data;
    end
  end
endmodule

`default_nettype wire

/* sim/flpew_ctrl_tb.sv */
// flpew_ctrl_tb: self-checking bench for the erase/write controller.
// Assumes the flash model above and shortened program times.
`timescale 1ns/10ps
`default_nettype none

module flpew_ctrl_tb;
  import flpew_pkg::*;

  localparam int E0 = 100;
  localparam int W0 = 120;
  localparam int E1 = 140;
  localparam int W1 = 160;

  logic ref_clk;
  logic rst_n;
  logic sfr_wr;
  flpew_idx_t sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] v;
  flpew_flash_s flash_cmd;
  int mismatches;
  int comparisons;
  int n;
  logic [7:0] pat [6];

  flpew_ctrl #(
    .ERASE0_CYC(E0),
    .WRITE0_CYC(W0),
    .ERASE1_CYC(E1),
    .WRITE1_CYC(W1)
  ) u_flpew_ctrl (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .flash_cmd(flash_cmd)
  );

  flpew_flash_model u_flpew_flash_model (
    .ref_clk(ref_clk),
    .flash_cmd(flash_cmd)
  );

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("counts: %0d mismatches, %0d comparisons", mismatches,
      comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // idle cycle after each write keeps strobe edges apart
  task automatic wr(input flpew_idx_t i, input logic [7:0] d);
    sfr_wr <= 1'b1;
    sfr_addr <= i;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input flpew_idx_t i, output logic [7:0] d);
    sfr_addr <= i;
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = sfr_rdata;
    @(posedge ref_clk);
  endtask

  task automatic quiet;
    repeat (6) begin
      @(negedge ref_clk);
      chk(flash_cmd.erase | flash_cmd.write, 1'b0);
    end
    @(posedge ref_clk);
  endtask

  task automatic op_len(output int len);
    len = 0;
    for (int k = 0; k < 8 && !(flash_cmd.erase | flash_cmd.write); k++)
      @(negedge ref_clk);
    while ((flash_cmd.erase | flash_cmd.write) === 1'b1 && len < 1000) begin
      len++;
      @(negedge ref_clk);
    end
    if (len == 0 || len == 1000) begin
      mismatches++;
      $display("FAIL %0t operation never ran or never ended", $time);
      print_verdict;
    end
    @(posedge ref_clk);
  endtask

  task automatic wait_clr;
    int k;
    for (k = 0; k < 60; k++) begin
      rd(IDX_CTRL2, v);
      if (v[0] === 1'b0) break;
    end
    if (k == 60) begin
      mismatches++;
      $display("FAIL %0t buffer clear never ended", $time);
      print_verdict;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 12; i++) begin
      rd(i[3:0], v);
      chk(v, 8'h00);
    end
    // index 12 is unmapped, word0 high skipped to avoid a buffer load
    for (int i = 2; i < 13; i++) begin
      if (i != 5) begin
        wr(i[3:0], 8'hff);
        rd(i[3:0], v);
        chk(v, i == 3 ? 8'h7f : i == 12 ? 8'h00 : 8'hff);
      end
    end
    $display("done t_regs");
  endtask

  task automatic t_locked;
    wr(IDX_CTRL0, 8'h94);
    quiet;
    rd(IDX_CTRL0, v);
    chk(v, 8'h10);
    $display("done t_locked");
  endtask

  task automatic t_unlock(input logic good);
    wr(IDX_CTRL0, 8'h68);
    for (int k = 0; k < 6; k++)
      wr(4'h6 + k[3:0], (good || k != 1) ? pat[k] : pat[k] ^ 8'h01);
    rd(IDX_CTRL0, v);
    chk(v, 8'h68);
    repeat (UNLOCK_CYC) @(posedge ref_clk);
    rd(IDX_CTRL0, v);
    chk(v, good ? 8'he0 : 8'h60);
    $display("done t_unlock");
  endtask

  task automatic t_tag;
    wr(IDX_ADDR_LOW, 8'h3e);
    wr(IDX_ADDR_HIGH, 8'h01);
    wr(4'h4, 8'h34);
    rd(IDX_ADDR_LOW, v);
    chk(v, 8'h3e);
    chk(flash_cmd.tag, 64'h0);
    wr(4'h5, 8'h12);
    rd(IDX_ADDR_LOW, v);
    chk(v, 8'h3f);
    chk(flash_cmd.tag, 64'h4000_0000_0000_0000);
    wr(4'h5, 8'h56);
    rd(IDX_ADDR_LOW, v);
    chk(v, 8'h3f);
    chk(flash_cmd.tag[63], 1'b1);
    chk(flash_cmd.page, 9'h004);
    $display("done t_tag");
  endtask

  task automatic t_erase;
    wr(IDX_CTRL2, 8'h00);
    wr(IDX_CTRL0, 8'h94);
    op_len(n);
    chk(n >= E0 - 3 && n <= E0 + 3, 1'b1);
    rd(IDX_CTRL0, v);
    chk(v, 8'h90);
    wait_clr;
    chk(u_flpew_flash_model.mem[15'h013e], 16'h0000);
    chk(u_flpew_flash_model.mem[15'h013f], 16'h0000);
    chk(u_flpew_flash_model.mem[15'h013d], 16'hffff);
    chk(flash_cmd.tag, 64'h0);
    $display("done t_erase");
  endtask

  task automatic t_write;
    wr(IDX_CTRL2, 8'h02);
    wr(IDX_ADDR_LOW, 8'h40);
    wr(IDX_ADDR_HIGH, 8'h01);
    wr(4'h4, 8'h34);
    wr(4'h5, 8'h12);
    wr(4'h4, 8'h78);
    wr(4'h5, 8'h56);
    wr(IDX_CTRL0, 8'h84);
    op_len(n);
    chk(n >= W1 - 3 && n <= W1 + 3, 1'b1);
    chk(u_flpew_flash_model.mem[15'h0140], 16'h1234);
    chk(u_flpew_flash_model.mem[15'h0141], 16'h5678);
    chk(u_flpew_flash_model.mem[15'h0142], 16'hffff);
    wait_clr;
    $display("done t_write");
  endtask

  task automatic t_clear;
    wr(IDX_ADDR_LOW, 8'h45);
    wr(4'h5, 8'h9a);
    // tag copy reaches the port one edge after the load
    @(posedge ref_clk);
    chk(flash_cmd.tag[5], 1'b1);
    wr(IDX_CTRL2, 8'h03);
    rd(IDX_CTRL2, v);
    chk(v, 8'h03);
    wait_clr;
    chk(v, 8'h02);
    chk(flash_cmd.tag, 64'h0);
    $display("done t_clear");
  endtask

  task automatic t_off;
    wr(IDX_CTRL0, 8'hb4);
    quiet;
    wr(IDX_CTRL0, 8'h00);
    rd(IDX_CTRL0, v);
    chk(v, 8'h00);
    wr(IDX_CTRL0, 8'h04);
    quiet;
    $display("done t_off");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = '0;
    sfr_wdata = '0;
    mismatches = 0;
    comparisons = 0;
    pat = '{PAT_W1L, PAT_W1H, PAT_W2L, PAT_W2H, PAT_W3L, PAT_W3H};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_locked;
    t_unlock(1'b0);
    t_unlock(1'b1);
    t_tag;
    t_erase;
    t_write;
    t_clear;
    t_off;
    print_verdict;
  end
endmodule

`default_nettype wire
